//--- logic/adctm_defs.svh
// Constants for the converter trigger and channel bank select block.
// Assumes an APB slave with 32-bit data and byte addresses, 100 MHz clock.
//
// Functional notes
// - With enable set, a rising edge ending a low trigger pulse starts a conversion.
// - Enabled external trigger and software start are ORed into one start.
// - Monitor output is low while the trigger enable bit is set.
// - A 7-bit channel select field picks one of 128 channels.
// - Channels 0 to 15 always belong to the converter's own inputs.
// - Identification read returns own code ORed with addressed board's code.
// - Trigger enable is read/write bit 4 of the control word.
// - Write-only start bit 0 starts a conversion only while done is clear.
// - Error bit 5 sets on any start while done or busy; data read clears it.
// - A read-only flag shows whether the addressed channel bank is installed.
`ifndef ADCTM_DEFS_SVH
`define ADCTM_DEFS_SVH

// Register byte offsets.
`define ADCTM_OFS_CSR 12'h000
`define ADCTM_OFS_DAT 12'h004
`define ADCTM_OFS_ID 12'h008
`define ADCTM_OFS_IST 12'h00C
`define ADCTM_OFS_IMSK 12'h010

// Control word fields.
`define ADCTM_CSR_START 0
`define ADCTM_CSR_TRIG_EN 4
`define ADCTM_CSR_ERR 5
`define ADCTM_CSR_IE 6
`define ADCTM_CSR_DONE 7
`define ADCTM_CSR_CHLO 8
`define ADCTM_CSR_CHHI 14
`define ADCTM_CSR_AVAIL 15

// Interrupt status bits.
`define ADCTM_IRQ_DONE 0
`define ADCTM_IRQ_ERR 1

// Own identification code, value arbitrary.
`define ADCTM_OWN_ID 8'h50

// Conversion time.
`define ADCTM_CONV_NS 10000
`define ADCTM_CLK_NS 10
`define ADCTM_CONV_CYC ((`ADCTM_CONV_NS + `ADCTM_CLK_NS - 1) / `ADCTM_CLK_NS)

`endif

//--- logic/adctm_pkg.sv
// Types for the converter trigger and channel bank select block.
// Assumes the constants header is included by the design files.
package adctm_pkg;
   typedef logic [6:0] adctm_chan_t;
   typedef enum logic [1:0] {
      ADCTM_IDLE = 2'b01,
      ADCTM_BUSY = 2'b10
   } adctm_state_e;
endpackage

//--- logic/adctm_trig_sync.sv
// Trigger pin synchroniser and trailing edge detector.
// Assumes an asynchronous, active-low trigger pin from the field.
`timescale 1ns/1ps
module adctm_trig_sync (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Pin and result.
   input wire logic i_pin_n,
   output logic o_rise
);
   logic meta;
   logic sync;
   logic last;
   logic next_meta;
   logic next_sync;
   logic next_last;

   // The first stage feeds only the second; the edge uses later stages.
   always_comb begin
      next_meta = i_pin_n;
      next_sync = meta;
      next_last = sync;
   end

   // Pin idles high, so reset loads ones to avoid a false edge.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= 1'b1;
         sync <= 1'b1;
         last <= 1'b1;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         last <= next_last;
      end
   end

   // Trailing edge of the low pulse gives one pulse.
   assign o_rise = sync & ~last;

   single_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_rise |=> !o_rise) else $error("trigger edge lasted two cycles");
endmodule

//--- logic/adctm_top.sv
// Converter control: trigger path, channel select, bank presence, APB registers.
// Assumes an APB master on i_clk and a converter core with start and result ports.
`timescale 1ns/1ps
`include "adctm_defs.svh"
module adctm_top (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Field pins.
   input wire logic i_external_trigger_pin_n,
   output logic o_trigger_enable_monitor_n,
   // Multiplexer cable.
   input wire logic [7:0] i_bank_present,
   input wire logic [7:0] i_mux_board_id,
   output logic [6:0] o_channel_select,
   // Converter core.
   output logic o_conv_start,
   input wire logic [11:0] i_conv_result,
   // Interrupt.
   output logic o_irq
);
   logic ext_rise;
   logic [7:0] present_s1;
   logic [7:0] present_s2;
   logic [7:0] id_s1;
   logic [7:0] id_s2;
   logic ext_trigger_enable_bit;
   logic ie;
   logic done;
   logic err;
   adctm_pkg::adctm_chan_t chan;
   adctm_pkg::adctm_state_e state;
   logic [15:0] count;
   logic [11:0] data;
   logic [1:0] ist;
   logic [1:0] imsk;
   logic [31:0] rdata;
   logic next_ext_trigger_enable_bit;
   logic next_ie;
   logic next_done;
   logic next_err;
   adctm_pkg::adctm_chan_t next_chan;
   adctm_pkg::adctm_state_e next_state;
   logic [15:0] next_count;
   logic [11:0] next_data;
   logic [1:0] next_ist;
   logic [1:0] next_imsk;
   logic [31:0] next_rdata;
   logic wr;
   logic rd;
   logic setup_rd;
   logic sw_start;
   logic ext_start;
   logic any_start;
   logic accept;
   logic refuse;
   logic finish;
   logic avail;
   logic [7:0] id_word;
   logic [31:0] csr_word;
   logic mapped;

   adctm_trig_sync u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin_n(i_external_trigger_pin_n),
      .o_rise(ext_rise)
   );

   // Cable inputs come from other boards and pass two flops.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         present_s1 <= 8'h00;
         present_s2 <= 8'h00;
         id_s1 <= 8'h00;
         id_s2 <= 8'h00;
      end else begin
         present_s1 <= i_bank_present;
         present_s2 <= present_s1;
         id_s1 <= i_mux_board_id;
         id_s2 <= id_s1;
      end
   end

   // APB decode; the slave answers with no wait states.
   assign o_pready = 1'b1;
   assign wr = i_psel & i_penable & i_pwrite;
   assign rd = i_psel & i_penable & ~i_pwrite;
   // Read data is captured at the setup edge, so it leaves a flop in the access cycle.
   assign setup_rd = i_psel & ~i_penable & ~i_pwrite;
   always_comb begin
      unique case (i_paddr)
         `ADCTM_OFS_CSR, `ADCTM_OFS_DAT, `ADCTM_OFS_ID, `ADCTM_OFS_IST, `ADCTM_OFS_IMSK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign o_pslverr = i_psel & i_penable & ~mapped;

   // Start sources and acceptance.
   assign sw_start = wr & (i_paddr == `ADCTM_OFS_CSR) & i_pwdata[`ADCTM_CSR_START] & ~done;
   assign ext_start = ext_trigger_enable_bit & ext_rise;
   assign any_start = sw_start | ext_start;
   assign refuse = (ext_start | (wr & (i_paddr == `ADCTM_OFS_CSR) & i_pwdata[`ADCTM_CSR_START]))
      & (done | (state == adctm_pkg::ADCTM_BUSY));
   assign accept = any_start & ~done & (state == adctm_pkg::ADCTM_IDLE);
   assign finish = (state == adctm_pkg::ADCTM_BUSY) && (count == 16'd0);

   // Bank 0 is always the board's own inputs; others need a board present.
   assign avail = (chan[6:4] == 3'd0) ? 1'b1 : present_s2[chan[6:4]];
   // Bank 0 never adds a board code.
   assign id_word = `ADCTM_OWN_ID | ((chan[6:4] == 3'd0) ? 8'h00 : id_s2);

   always_comb begin
      csr_word = 32'h0000_0000;
      csr_word[`ADCTM_CSR_TRIG_EN] = ext_trigger_enable_bit;
      csr_word[`ADCTM_CSR_ERR] = err;
      csr_word[`ADCTM_CSR_IE] = ie;
      csr_word[`ADCTM_CSR_DONE] = done;
      csr_word[`ADCTM_CSR_CHHI:`ADCTM_CSR_CHLO] = chan;
      csr_word[`ADCTM_CSR_AVAIL] = avail;
   end

   // Next state of control, conversion and interrupt registers.
   always_comb begin
      next_ext_trigger_enable_bit = ext_trigger_enable_bit;
      next_ie = ie;
      next_chan = chan;
      next_imsk = imsk;
      next_state = state;
      next_count = count;
      next_data = data;
      next_done = done;
      next_err = err;
      next_ist = ist;
      next_rdata = 32'h0000_0000;
      if (wr && i_paddr == `ADCTM_OFS_CSR) begin
         next_ext_trigger_enable_bit = i_pwdata[`ADCTM_CSR_TRIG_EN];
         next_ie = i_pwdata[`ADCTM_CSR_IE];
         next_chan = i_pwdata[`ADCTM_CSR_CHHI:`ADCTM_CSR_CHLO];
      end
      if (wr && i_paddr == `ADCTM_OFS_IMSK) begin
         next_imsk = i_pwdata[1:0];
      end
      // Write one clears status; a new event in the same cycle wins.
      if (wr && i_paddr == `ADCTM_OFS_IST) begin
         next_ist = ist & ~i_pwdata[1:0];
      end
      // Data read clears done and error; a refusal in the same cycle wins.
      if (rd && i_paddr == `ADCTM_OFS_DAT) begin
         next_done = 1'b0;
         next_err = 1'b0;
      end
      unique case (state)
         adctm_pkg::ADCTM_IDLE: begin
            if (accept) begin
               next_state = adctm_pkg::ADCTM_BUSY;
               next_count = 16'(`ADCTM_CONV_CYC - 1);
            end
         end
         adctm_pkg::ADCTM_BUSY: begin
            if (finish) begin
               next_state = adctm_pkg::ADCTM_IDLE;
               next_data = i_conv_result;
               next_done = 1'b1;
               next_ist[`ADCTM_IRQ_DONE] = 1'b1;
            end else begin
               next_count = count - 16'd1;
            end
         end
         default: begin
            next_state = adctm_pkg::ADCTM_IDLE;
         end
      endcase
      if (refuse) begin
         next_err = 1'b1;
         next_ist[`ADCTM_IRQ_ERR] = 1'b1;
      end
      // A cable change between setup and access is not seen until the next read.
      if (setup_rd) begin
         unique case (i_paddr)
            `ADCTM_OFS_CSR: next_rdata = csr_word;
            `ADCTM_OFS_DAT: next_rdata = {20'h0_0000, data};
            `ADCTM_OFS_ID: next_rdata = {24'h00_0000, id_word};
            `ADCTM_OFS_IST: next_rdata = {30'h0000_0000, ist};
            `ADCTM_OFS_IMSK: next_rdata = {30'h0000_0000, imsk};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Register stage.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_trigger_enable_bit <= 1'b0;
         ie <= 1'b0;
         chan <= 7'h00;
         imsk <= 2'h0;
         state <= adctm_pkg::ADCTM_IDLE;
         count <= 16'h0000;
         data <= 12'h000;
         done <= 1'b0;
         err <= 1'b0;
         ist <= 2'h0;
         rdata <= 32'h0000_0000;
      end else begin
         ext_trigger_enable_bit <= next_ext_trigger_enable_bit;
         ie <= next_ie;
         chan <= next_chan;
         imsk <= next_imsk;
         state <= next_state;
         count <= next_count;
         data <= next_data;
         done <= next_done;
         err <= next_err;
         ist <= next_ist;
         rdata <= next_rdata;
      end
   end

   // Read data stands from the flop for the whole access cycle.
   assign o_prdata = rdata;
   assign o_trigger_enable_monitor_n = ~ext_trigger_enable_bit;
   assign o_channel_select = chan;
   assign o_conv_start = accept;
   assign o_irq = ie & |(ist & imsk);

   sequence trig_seq;
      ext_trigger_enable_bit && ext_rise && !done && state == adctm_pkg::ADCTM_IDLE;
   endsequence

   // Counter loaded for a full conversion on the cycle after a start.
   sequence conv_loaded_seq;
      state == adctm_pkg::ADCTM_BUSY && count == 16'(`ADCTM_CONV_CYC - 1);
   endsequence

   // Back to idle with done and its event bit set.
   sequence conv_ended_seq;
      state == adctm_pkg::ADCTM_IDLE && done && ist[`ADCTM_IRQ_DONE];
   endsequence

   // Trigger path: an enabled edge starts a conversion, a disabled pin is ignored.
   ext_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      trig_seq |-> o_conv_start ##1 state == adctm_pkg::ADCTM_BUSY) else $error("enabled trigger lost");
   ext_ignored_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !ext_trigger_enable_bit && !sw_start |-> !o_conv_start) else $error("trigger used while disabled");

   // Either source raises the same start, which loads the conversion counter.
   start_or_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_conv_start |-> (sw_start || ext_start) && !done) else $error("start without source");
   conv_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_conv_start |=> conv_loaded_seq) else $error("conversion counter not loaded");

   // Monitor pin tracks the enable bit, also right after a write.
   monitor_pin_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(ext_trigger_enable_bit) |-> !o_trigger_enable_monitor_n) else $error("monitor not low");
   monitor_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      wr && i_paddr == `ADCTM_OFS_CSR |=> o_trigger_enable_monitor_n == !$past(i_pwdata[`ADCTM_CSR_TRIG_EN]))
      else $error("monitor does not follow enable");

   // Channel field written by software reaches the cable.
   chan_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      wr && i_paddr == `ADCTM_OFS_CSR |=> o_channel_select == $past(i_pwdata[`ADCTM_CSR_CHHI:`ADCTM_CSR_CHLO]))
      else $error("channel lost");

   // Bank zero is the board's own; other banks add the addressed board's code.
   bank0_avail_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      chan[6:4] == 3'd0 |-> avail && id_word == `ADCTM_OWN_ID) else $error("bank zero wrong");
   id_or_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      chan[6:4] != 3'd0 |-> id_word == (`ADCTM_OWN_ID | id_s2)) else $error("id not ored");
   id_capture_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      setup_rd && i_paddr == `ADCTM_OFS_ID |=> o_prdata == {24'h00_0000, $past(id_word)})
      else $error("id read wrong");

   // Starts are blocked by done; a clean software start is taken at once.
   done_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      done |-> !o_conv_start) else $error("start while done");
   sw_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      wr && i_paddr == `ADCTM_OFS_CSR && i_pwdata[`ADCTM_CSR_START] && !done && state == adctm_pkg::ADCTM_IDLE
      |-> o_conv_start) else $error("software start lost");
   conv_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      finish |=> conv_ended_seq ##0 data == $past(i_conv_result)) else $error("conversion end lost");

   // Error flag: set by a refused start, cleared by a data read otherwise.
   err_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      refuse |=> err ##0 ist[`ADCTM_IRQ_ERR]) else $error("error flag missing");
   busy_refuse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ext_start && state == adctm_pkg::ADCTM_BUSY |=> err && ist[`ADCTM_IRQ_ERR]) else $error("busy trigger not refused");
   err_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd && i_paddr == `ADCTM_OFS_DAT && !refuse |=> !err) else $error("error not cleared by data read");
   done_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd && i_paddr == `ADCTM_OFS_DAT && !finish |=> !done) else $error("done not cleared by data read");

   // Control word read shows the enable bit and the presence flag.
   trig_en_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd && i_paddr == `ADCTM_OFS_CSR |-> o_prdata[4] == ext_trigger_enable_bit) else $error("enable bit wrong");
   avail_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd && i_paddr == `ADCTM_OFS_CSR |-> o_prdata[15] == avail) else $error("present flag wrong");
endmodule

//--- dv/adctm_field_model.sv
// Field side model: trigger source and switch-set expansion multiplexer boards.
// Assumes the converter drives the channel address on i_clk.
`timescale 1ns/1ps
module adctm_field_model #(
   parameter logic [7:0] FITTED = 8'h0e
) (
   // Clock.
   input wire logic i_clk,
   // Multiplexer cable.
   input wire logic [6:0] i_channel_select,
   output logic [7:0] o_bank_present,
   output logic [7:0] o_mux_board_id,
   // Trigger pin.
   output logic o_trigger_pin_n
);
   logic [2:0] bank;

   // Bank zero is the converter's own, so no board may sit there; at most seven remain.
   assign o_bank_present = FITTED & 8'hfe;
   assign bank = i_channel_select[6:4];
   // Only the board set to the addressed bank answers; the lines are pulled low otherwise.
   // Board codes are the bank number, an arbitrary choice.
   assign o_mux_board_id = o_bank_present[bank] ? {5'h00, bank} : 8'h00;

   initial o_trigger_pin_n = 1'b1;

   // Low pulse of a given number of cycles; the trailing edge is what counts.
   task automatic fire(input int len);
      @(posedge i_clk);
      o_trigger_pin_n <= 1'b0;
      repeat (len) @(posedge i_clk);
      o_trigger_pin_n <= 1'b1;
   endtask
endmodule

//--- dv/adc_trigger_and_mux_bank_select_test.sv
// Self-checking bench for the converter trigger and channel bank select block.
// Assumes the field model is compiled first and APB answers with no wait states.
`timescale 1ns/1ps
`include "adctm_defs.svh"
module adc_trigger_and_mux_bank_select_test;
   typedef struct packed {logic err; logic [31:0] mask; logic [31:0] data;} adctm_note_s;
   localparam logic [7:0] FITTED = 8'h0e;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [11:0] result = 12'h000;
   logic [31:0] prdata;
   logic pready, pslverr, mon_n, conv_start, irq, pin_n;
   logic [6:0] chan, c;
   logic [7:0] present, board_id;
   int failures = 0;
   int samples_checked = 0;
   int starts = 0;
   int seed = 32'h8f4d;
   adctm_note_s notes[$];
   adctm_note_s cur;

   always #5 i_clk = ~i_clk;

   adctm_top i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_external_trigger_pin_n(pin_n), .o_trigger_enable_monitor_n(mon_n),
      .i_bank_present(present), .i_mux_board_id(board_id), .o_channel_select(chan),
      .o_conv_start(conv_start), .i_conv_result(result), .o_irq(irq));
   adctm_field_model #(.FITTED(FITTED)) i_field (.i_clk(i_clk), .i_channel_select(chan),
      .o_bank_present(present), .o_mux_board_id(board_id), .o_trigger_pin_n(pin_n));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatched %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Each completed transfer takes the oldest note; writes only check the error reply.
   always @(posedge i_clk) begin
      if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
         cur = notes.pop_front();
         chk(prdata & cur.mask, cur.data);
         chk({31'h0, pslverr}, {31'h0, cur.err});
      end
   end

   // Start pulses last one cycle, so they are counted edge by edge.
   always @(posedge i_clk) begin
      if (conv_start === 1'b1) starts++;
   end

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic e);
      notes.push_back({e, w ? 32'h0 : m, w ? 32'h0 : d & m});
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      apb(1'b0, a, d, m, 1'b0);
   endtask

   task automatic pulse_and_count(input int exp);
      i_field.fire(3);
      repeat (6) @(posedge i_clk);
      chk(starts, exp);
   endtask

   initial begin
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      chk({31'h0, mon_n}, 32'h1);
      rd(`ADCTM_OFS_CSR, 32'h0000_8000, 32'h0000_fff0);
      apb(1'b0, 12'h014, 32'h0, 32'hffff_ffff, 1'b1);
      apb(1'b1, 12'h018, 32'hffff_ffff, 32'h0, 1'b1);
      $display("reset and decode test ended");
      // External trigger: ignored while disabled, then one start; a second pulse and a software start are refused while done.
      result <= 12'($random(seed));
      wr(`ADCTM_OFS_IMSK, 32'h0000_0003);
      pulse_and_count(0);
      wr(`ADCTM_OFS_CSR, 32'h0000_0050);
      @(posedge i_clk);
      chk({31'h0, mon_n}, 32'h0);
      rd(`ADCTM_OFS_CSR, 32'h0000_0050, 32'h0000_0050);
      pulse_and_count(1);
      repeat (`ADCTM_CONV_CYC + 5) @(posedge i_clk);
      rd(`ADCTM_OFS_CSR, 32'h0000_0080, 32'h0000_00a0);
      chk({31'h0, irq}, 32'h1);
      rd(`ADCTM_OFS_IST, 32'h0000_0001, 32'h0000_0003);
      rd(`ADCTM_OFS_IMSK, 32'h0000_0003, 32'h0000_0003);
      pulse_and_count(1);
      wr(`ADCTM_OFS_CSR, 32'h0000_0051);
      repeat (2) @(posedge i_clk);
      chk(starts, 1);
      rd(`ADCTM_OFS_CSR, 32'h0000_00a0, 32'h0000_00a0);
      rd(`ADCTM_OFS_DAT, {20'h0, result}, 32'h0000_0fff);
      rd(`ADCTM_OFS_CSR, 32'h0, 32'h0000_00a0);
      wr(`ADCTM_OFS_IST, 32'h0000_0003);
      @(posedge i_clk);
      chk({31'h0, irq}, 32'h0);
      $display("external trigger test ended");
      // Software start, then a trigger while busy, interrupt masked.
      result <= 12'($random(seed));
      wr(`ADCTM_OFS_IMSK, 32'h0);
      wr(`ADCTM_OFS_CSR, 32'h0000_0051);
      repeat (2) @(posedge i_clk);
      chk(starts, 2);
      pulse_and_count(2);
      rd(`ADCTM_OFS_CSR, 32'h0000_0020, 32'h0000_00a0);
      chk({31'h0, irq}, 32'h0);
      repeat (`ADCTM_CONV_CYC + 5) @(posedge i_clk);
      rd(`ADCTM_OFS_DAT, {20'h0, result}, 32'h0000_0fff);
      wr(`ADCTM_OFS_IST, 32'h0000_0003);
      $display("software start test ended");
      // Every bank once, with a random channel inside it.
      for (int b = 0; b < 8; b++) begin
         c = {3'(b), 4'($random(seed))};
         wr(`ADCTM_OFS_CSR, {17'h0, c, 8'h10});
         repeat (3) @(posedge i_clk);
         chk({25'h0, chan}, {25'h0, c});
         rd(`ADCTM_OFS_CSR, {16'h0, 1'(FITTED[b] || b == 0), c, 8'h00}, 32'h0000_ff00);
         rd(`ADCTM_OFS_ID, {24'h0, `ADCTM_OWN_ID | (b > 0 && FITTED[b] ? 8'(b) : 8'h00)},
            32'h0000_00ff);
      end
      $display("channel bank test ended");
      summarize();
   end

   // The run needs about 2200 cycles; this allows about nine times that.
   initial begin
      #200000;
      failures++;
      summarize();
   end
endmodule
